// *** hw/mpm_top.sv ***
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module mpm_top import mpm_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [5:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [5:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic decode_a_high_in,
  input wire logic decode_a_low_in,
  input wire logic decode_b_high_in,
  input wire logic decode_b_low_in,
  input wire logic protect_in,
  input wire logic filtered_hall_input_in,
  output logic pair_a_high_out,
  output logic pair_a_low_out,
  output logic pair_b_high_out,
  output logic pair_b_low_out,
  output logic duty_event_out
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [3:0] sync;
    logic [7:0] motor_mask_config;
    logic [7:0] aux;
    logic [3:0] men;
    logic [3:0] mlvl;
    logic [1:0] hold_d0;
    logic [1:0] hold_d1;
    logic [1:0] hold_p;
    logic [9:0] buf_d0;
    logic [9:0] buf_d1;
    logic [9:0] buf_p;
    logic [9:0] act_d0;
    logic [9:0] act_d1;
    logic [9:0] act_p;
    logic [9:0] cnt;
    logic down;
    logic [2:0] div;
    logic [3:0] dec;
    logic [3:0] gate;
    logic evt;
    logic awr;
    logic wr;
    logic bv;
    logic [1:0] bresp;
    logic arr;
    logic rv;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mpm_state_s;

  mpm_state_s st_r;
  mpm_state_s st_nxt;

  // {high, low} of one pair from its two-bit decode
  function automatic logic [1:0] mpm_hw_pair(input logic [1:0] dec, input logic pwm,
                                             input logic side, input logic noncomp);
    logic npwm;
    logic [1:0] o;
    npwm = noncomp ? 1'b0 : ~pwm;
    o = 2'b00;
    case (dec)
      2'b01: o = side ? 2'b01 : {npwm, pwm};
      2'b10: o = side ? {pwm, npwm} : 2'b10;
      default: o = 2'b00;
    endcase
    return o;
  endfunction

  // {high, low}; a channel masked beside a live one cannot be held high
  function automatic logic [1:0] mpm_sw_pair(input logic [1:0] en, input logic [1:0] lvl,
                                             input logic pwm);
    logic [1:0] o;
    o[1] = en[1] ? lvl[1] : pwm;
    o[0] = en[0] ? lvl[0] : pwm;
    if (&en && &lvl) begin
      o = 2'b00;
    end else if (^en) begin
      o = {en[1] ? 1'b0 : pwm, en[0] ? 1'b0 : pwm};
    end
    return o;
  endfunction

  logic on, centre, tick, peak, under, ovf, rpoint, ld, quick;
  logic pwm0, pwm1, aw_hs, ar_hs, we;
  logic [1:0] align, cks;
  logic [3:0] dec_in, men_eff;
  logic [7:0] wb;

  assign on = st_r.ctrl[CTRL_ON_BIT];
  assign align = st_r.ctrl[CTRL_ALIGN_LSB +: 2];
  assign cks = st_r.ctrl[CTRL_CKS_LSB +: 2];
  assign centre = align[1];
  // one-cycle enable from the divider keeps a single clock domain
  assign tick = (cks == CKS_DIV1) ? 1'b1 :
                (cks == CKS_DIV2) ? st_r.div[0] :
                (cks == CKS_DIV4) ? &st_r.div[1:0] : &st_r.div;
  assign peak = on & tick & centre & ~st_r.down & (st_r.cnt >= st_r.act_p);
  assign under = on & tick & centre & st_r.down & (st_r.cnt <= 10'h001);
  assign ovf = on & tick & ~centre & (st_r.cnt >= st_r.act_p);
  assign rpoint = ovf | under | (peak & (align == ALIGN_CENTRE2));
  // a stopped counter has no boundary, so buffers pass straight through
  assign ld = st_r.ctrl[CTRL_RELOAD_BIT] & (rpoint | ~on);
  assign quick = st_r.sync[SYNC_QUICK_BIT];
  assign pwm0 = on & (st_r.cnt < st_r.act_d0);
  assign pwm1 = on & (st_r.cnt < st_r.act_d1);
  assign dec_in = {decode_b_low_in, decode_b_high_in, decode_a_low_in, decode_a_high_in};
  assign men_eff = st_r.men & ~st_r.aux[AUX_GPIO_LSB +: 4];
  assign aw_hs = st_r.awr & s_axi_awvalid_in & st_r.wr & s_axi_wvalid_in;
  assign ar_hs = st_r.arr & s_axi_arvalid_in;
  assign we = aw_hs & s_axi_wstrb_in[0];
  assign wb = s_axi_wdata_in[7:0];

  always_comb begin
    logic p0, p1;
    logic [1:0] pa, pb;
    logic [7:0] rb;
    logic hit;
    st_nxt = st_r;
    p0 = 1'b0;
    p1 = 1'b0;
    pa = 2'b00;
    pb = 2'b00;
    rb = 8'h00;
    hit = 1'b1;
    // counter
    st_nxt.div = on ? st_r.div + 3'd1 : 3'd0;
    if (on && tick) begin
      if (!centre) begin
        st_nxt.cnt = ovf ? 10'h000 : st_r.cnt + 10'd1;
        st_nxt.down = 1'b0;
      end else if (!st_r.down) begin
        st_nxt.cnt = peak ? st_r.cnt - 10'd1 : st_r.cnt + 10'd1;
        st_nxt.down = peak;
      end else begin
        st_nxt.cnt = under ? 10'h000 : st_r.cnt - 10'd1;
        st_nxt.down = ~under;
      end
    end
    st_nxt.evt = on & tick & centre & (st_r.cnt == st_r.act_d0) &
                 (st_r.down ? st_r.ctrl[CTRL_IRQ_LSB + 1] : st_r.ctrl[CTRL_IRQ_LSB]);
    // buffered reload; the hardware clear is applied before a bus write so a set wins
    if (ld) begin
      st_nxt.act_p = st_r.buf_p;
      if (st_r.sync[SYNC_EN_BIT]) begin
        if (st_r.sync[SYNC_REQ_BIT]) begin
          st_nxt.act_d0 = st_r.buf_d0;
          st_nxt.act_d1 = st_r.buf_d1;
          st_nxt.sync[SYNC_REQ_BIT] = 1'b0;
        end
      end else begin
        st_nxt.act_d0 = st_r.buf_d0;
        st_nxt.act_d1 = st_r.buf_d1;
      end
    end
    // phase change waits for the next rpoint unless quick update is on or the counter is stopped
    if (quick || rpoint || !on) begin
      st_nxt.dec = dec_in;
    end
    // register writes
    st_nxt.awr = 1'b0;
    st_nxt.wr = 1'b0;
    if (s_axi_awvalid_in && s_axi_wvalid_in && !st_r.awr && !st_r.bv) begin
      st_nxt.awr = 1'b1;
      st_nxt.wr = 1'b1;
    end
    if (aw_hs) begin
      st_nxt.bv = 1'b1;
      st_nxt.bresp = AXI_OKAY;
      case (s_axi_awaddr_in)
        OFS_MAIN_CTRL, OFS_SYNC_CTRL, OFS_DUTY0_LO, OFS_DUTY0_HI, OFS_DUTY1_LO,
        OFS_DUTY1_HI, OFS_PERIOD_LO, OFS_PERIOD_HI, OFS_COUNT_LO, OFS_COUNT_HI,
        OFS_MASK_CFG, OFS_DRV_STATUS, OFS_MASK_EN, OFS_MASK_LVL, OFS_AUX_CTRL: ;
        default: st_nxt.bresp = AXI_SLVERR;
      endcase
    end else if (st_r.bv && s_axi_bready_in) begin
      st_nxt.bv = 1'b0;
    end
    if (we) begin
      case (s_axi_awaddr_in)
        OFS_MAIN_CTRL: st_nxt.ctrl = wb;
        OFS_SYNC_CTRL: st_nxt.sync = wb[3:0];
        OFS_DUTY0_HI: st_nxt.hold_d0 = wb[1:0];
        OFS_DUTY1_HI: st_nxt.hold_d1 = wb[1:0];
        OFS_PERIOD_HI: st_nxt.hold_p = wb[1:0];
        OFS_DUTY0_LO: begin
          st_nxt.buf_d0 = {st_r.hold_d0, wb};
          if (st_r.sync[SYNC_COPY_BIT] && st_r.ctrl[CTRL_RELOAD_BIT]) begin
            st_nxt.buf_d1 = {st_r.hold_d0, wb};
          end
        end
        OFS_DUTY1_LO: st_nxt.buf_d1 = {st_r.hold_d1, wb};
        OFS_PERIOD_LO: st_nxt.buf_p = {st_r.hold_p, wb};
        OFS_MASK_CFG: st_nxt.motor_mask_config = wb & MCF_WMASK;
        OFS_MASK_EN: st_nxt.men = wb[3:0];
        OFS_MASK_LVL: st_nxt.mlvl = wb[3:0];
        OFS_AUX_CTRL: st_nxt.aux = wb & AUX_WMASK;
        default: ;
      endcase
    end
    // register reads; write-only values read as zero
    st_nxt.arr = s_axi_arvalid_in & ~st_r.arr & ~st_r.rv;
    case (s_axi_araddr_in)
      OFS_MAIN_CTRL: rb = st_r.ctrl;
      OFS_SYNC_CTRL: rb = {4'h0, st_r.sync};
      OFS_COUNT_LO: rb = st_r.cnt[7:0];
      OFS_COUNT_HI: rb = {6'h00, st_r.cnt[9:8]};
      OFS_MASK_CFG: rb = st_r.motor_mask_config;
      OFS_DRV_STATUS: rb = {2'b00, st_r.gate[CH_AH], st_r.gate[CH_AL], st_r.gate[CH_BH],
                            2'b00, filtered_hall_input_in};
      OFS_MASK_EN: rb = {4'h0, st_r.men};
      OFS_MASK_LVL: rb = {4'h0, st_r.mlvl};
      OFS_AUX_CTRL: rb = st_r.aux;
      OFS_DUTY0_LO, OFS_DUTY0_HI, OFS_DUTY1_LO, OFS_DUTY1_HI,
      OFS_PERIOD_LO, OFS_PERIOD_HI: rb = 8'h00;
      default: hit = 1'b0;
    endcase
    if (ar_hs) begin
      st_nxt.rv = 1'b1;
      st_nxt.rdata = {24'h000000, rb};
      st_nxt.rresp = hit ? AXI_OKAY : AXI_SLVERR;
    end else if (st_r.rv && s_axi_rready_in) begin
      st_nxt.rv = 1'b0;
    end
    // mask stage; a cleared output enable holds the drive unmodulated
    p0 = st_r.motor_mask_config[MCF_OE_BIT] ? pwm0 : 1'b1;
    p1 = st_r.motor_mask_config[MCF_OE_BIT] ? pwm1 : 1'b1;
    if (st_r.motor_mask_config[MCF_SWMASK_BIT]) begin
      pa = mpm_sw_pair({men_eff[CH_AH], men_eff[CH_AL]},
                       {st_r.mlvl[CH_AH], st_r.mlvl[CH_AL]}, p0);
      pb = mpm_sw_pair({men_eff[CH_BH], men_eff[CH_BL]},
                       {st_r.mlvl[CH_BH], st_r.mlvl[CH_BL]}, p1);
    end else begin
      pa = mpm_hw_pair({st_r.dec[CH_AH], st_r.dec[CH_AL]}, p0, st_r.motor_mask_config[MCF_SIDE_BIT],
                       st_r.motor_mask_config[MCF_NONCOMP_BIT]);
      pb = mpm_hw_pair({st_r.dec[CH_BH], st_r.dec[CH_BL]}, p1, st_r.motor_mask_config[MCF_SIDE_BIT],
                       st_r.motor_mask_config[MCF_NONCOMP_BIT]);
    end
    if (st_r.aux[AUX_BRAKE_BIT]) begin
      pa = 2'b01;
      pb = 2'b01;
    end else if (protect_in) begin
      pa = {1'b0, st_r.motor_mask_config[MCF_PROTECTION_OUTPUT_SELECT_BIT]};
      pb = {1'b0, st_r.motor_mask_config[MCF_PROTECTION_OUTPUT_SELECT_BIT]};
    end
    st_nxt.gate = {pb[0], pb[1], pa[0], pa[1]};
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      st_r <= '0;
      st_r.ctrl <= MAIN_CTRL_RST;
      st_r.sync <= SYNC_CTRL_RST;
      st_r.motor_mask_config <= MCF_RST;
      st_r.aux <= AUX_RST;
      st_r.buf_p <= VAL10_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready_out = st_r.awr;
  assign s_axi_wready_out = st_r.wr;
  assign s_axi_bvalid_out = st_r.bv;
  assign s_axi_bresp_out = st_r.bresp;
  assign s_axi_arready_out = st_r.arr;
  assign s_axi_rvalid_out = st_r.rv;
  assign s_axi_rdata_out = st_r.rdata;
  assign s_axi_rresp_out = st_r.rresp;
  assign pair_a_high_out = st_r.gate[CH_AH];
  assign pair_a_low_out = st_r.gate[CH_AL];
  assign pair_b_high_out = st_r.gate[CH_BH];
  assign pair_b_low_out = st_r.gate[CH_BL];
  assign duty_event_out = st_r.evt;

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  sequence s_div8_gap;
    !tick [*7] ##1 tick;
  endsequence

  property p_div8;
    (on && cks == 2'h3 && tick) ##1 (on && cks == 2'h3) |-> s_div8_gap;
  endproperty
  a_div8: assert property (p_div8) else $error("divide by eight spacing wrong");

  property p_stop_holds;
    !on |=> $stable(st_r.cnt);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("counter moved while off");

  property p_edge_wrap;
    ovf |=> st_r.cnt == 10'h000;
  endproperty
  a_edge_wrap: assert property (p_edge_wrap) else $error("edge counter missed wrap");

  property p_sync_load;
    ld && st_r.sync[SYNC_EN_BIT] && st_r.sync[SYNC_REQ_BIT] && !we |=>
      !st_r.sync[SYNC_REQ_BIT] && st_r.act_d0 == $past(st_r.buf_d0) &&
      st_r.act_d1 == $past(st_r.buf_d1);
  endproperty
  a_sync_load: assert property (p_sync_load) else $error("sync duty load wrong");

  property p_brake;
    st_r.aux[AUX_BRAKE_BIT] |=> pair_a_low_out && pair_b_low_out &&
      !pair_a_high_out && !pair_b_high_out;
  endproperty
  a_brake: assert property (p_brake) else $error("brake drive wrong");

  property p_protect_off;
    protect_in && !st_r.aux[AUX_BRAKE_BIT] && !st_r.motor_mask_config[MCF_PROTECTION_OUTPUT_SELECT_BIT] |=>
      st_r.gate == 4'h0;
  endproperty
  a_protect_off: assert property (p_protect_off) else $error("protection not off");

  sequence s_rd_count;
    ar_hs && s_axi_araddr_in == OFS_COUNT_LO;
  endsequence

  property p_count_read;
    s_rd_count |=> s_axi_rvalid_out && s_axi_rdata_out[7:0] == $past(st_r.cnt[7:0]);
  endproperty
  a_count_read: assert property (p_count_read) else $error("counter read wrong");

  property p_hi_hold;
    we && s_axi_awaddr_in == OFS_PERIOD_HI |=> $stable(st_r.buf_p);
  endproperty
  a_hi_hold: assert property (p_hi_hold) else $error("high byte committed early");

  property p_no_reload;
    !st_r.ctrl[CTRL_RELOAD_BIT] |=> $stable(st_r.act_p);
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("period reloaded while off");

  property p_pair_zero;
    st_r.motor_mask_config[MCF_SWMASK_BIT] && !st_r.aux[AUX_BRAKE_BIT] && !protect_in &&
      &men_eff[1:0] && &st_r.mlvl[1:0] |=> !pair_a_high_out && !pair_a_low_out;
  endproperty
  a_pair_zero: assert property (p_pair_zero) else $error("masked pair not zero");

endmodule
`default_nettype wire

// *** inc/mpm_pkg.sv ***
package mpm_pkg;
  localparam logic [5:0] OFS_MAIN_CTRL = 6'h00;
  localparam logic [5:0] OFS_SYNC_CTRL = 6'h04;
  localparam logic [5:0] OFS_DUTY0_LO = 6'h08;
  localparam logic [5:0] OFS_DUTY0_HI = 6'h0C;
  localparam logic [5:0] OFS_DUTY1_LO = 6'h10;
  localparam logic [5:0] OFS_DUTY1_HI = 6'h14;
  localparam logic [5:0] OFS_PERIOD_LO = 6'h18;
  localparam logic [5:0] OFS_PERIOD_HI = 6'h1C;
  localparam logic [5:0] OFS_COUNT_LO = 6'h20;
  localparam logic [5:0] OFS_COUNT_HI = 6'h24;
  localparam logic [5:0] OFS_MASK_CFG = 6'h28;
  localparam logic [5:0] OFS_DRV_STATUS = 6'h2C;
  localparam logic [5:0] OFS_MASK_EN = 6'h30;
  localparam logic [5:0] OFS_MASK_LVL = 6'h34;
  localparam logic [5:0] OFS_AUX_CTRL = 6'h38;
  localparam int CTRL_RELOAD_BIT = 0;
  localparam int CTRL_IRQ_LSB = 1;
  localparam int CTRL_ON_BIT = 3;
  localparam int CTRL_CKS_LSB = 4;
  localparam int CTRL_ALIGN_LSB = 6;
  localparam int SYNC_COPY_BIT = 0;
  localparam int SYNC_EN_BIT = 1;
  localparam int SYNC_REQ_BIT = 2;
  localparam int SYNC_QUICK_BIT = 3;
  localparam int MCF_SIDE_BIT = 0;
  localparam int MCF_PROTECTION_OUTPUT_SELECT_BIT = 1;
  localparam int MCF_OE_BIT = 2;
  localparam int MCF_NONCOMP_BIT = 3;
  localparam int MCF_SWMASK_BIT = 7;
  localparam int AUX_BRAKE_BIT = 0;
  localparam int AUX_GPIO_LSB = 4;
  localparam int ST_GAT_BIT = 5;
  localparam int CH_AH = 0;
  localparam int CH_AL = 1;
  localparam int CH_BH = 2;
  localparam int CH_BL = 3;
  localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
  localparam logic [3:0] SYNC_CTRL_RST = 4'h0;
  localparam logic [7:0] MCF_RST = 8'h04;
  localparam logic [7:0] MCF_WMASK = 8'h8F;
  localparam logic [7:0] AUX_RST = 8'h00;
  localparam logic [7:0] AUX_WMASK = 8'hF1;
  localparam logic [9:0] VAL10_RST = 10'h000;
  localparam logic [1:0] ALIGN_CENTRE2 = 2'h3;
  localparam logic [1:0] CKS_DIV1 = 2'h0;
  localparam logic [1:0] CKS_DIV2 = 2'h1;
  localparam logic [1:0] CKS_DIV4 = 2'h2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// *** tb/mpm_gate_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module mpm_gate_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic a_high_in,
  input wire logic a_low_in,
  input wire logic b_high_in,
  input wire logic b_low_in,
  output var int shorts_out
);
  // both transistors of a pair on shorts the rail; no dead time exists in this block
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      shorts_out <= 0;
    end else if ((a_high_in && a_low_in) || (b_high_in && b_low_in)) begin
      shorts_out <= shorts_out + 1;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top import mpm_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] awaddr = '0;
  logic [5:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] dec = 4'b0010;
  logic protect = 1'b0;
  logic hall = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, ah, al, bh, bl, ev;
  logic [1:0] bresp, rresp, wr_resp, rd_resp;
  logic [31:0] rdata, rd_data;
  int shorts, c_ah, c_al, c_bl, c_r, c_ev;
  int failures = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  mpm_top dut (.clk_sys_in(clk), .rstn_in(rstn), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .decode_a_high_in(dec[3]), .decode_a_low_in(dec[2]),
    .decode_b_high_in(dec[1]), .decode_b_low_in(dec[0]), .protect_in(protect),
    .filtered_hall_input_in(hall), .pair_a_high_out(ah), .pair_a_low_out(al),
    .pair_b_high_out(bh), .pair_b_low_out(bl), .duty_event_out(ev));
  mpm_gate_model model (.clk_in(clk), .rstn_in(rstn), .a_high_in(ah), .a_low_in(al),
    .b_high_in(bh), .b_low_in(bl), .shorts_out(shorts));
  task automatic summarize;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      failures++;
      $display("CHECK FAILED t=%0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    wr_resp = bresp;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_data = rdata;
    rd_resp = rresp;
  endtask
  // whole periods only, so counts do not depend on where the window starts
  task automatic meas;
    logic prev;
    c_ah = 0;
    c_al = 0;
    c_bl = 0;
    c_r = 0;
    c_ev = 0;
    prev = al;
    repeat (360) begin
      @(posedge clk);
      c_ah += (ah === 1'b1);
      c_al += (al === 1'b1);
      c_bl += (bl === 1'b1);
      c_ev += (ev === 1'b1);
      c_r += (al === 1'b1 && prev !== 1'b1);
      prev = al;
    end
  endtask
  task automatic run_row(input logic [7:0] m, f, da, me, ml, ax, input int eah, eal, er, eev);
    wr(OFS_MAIN_CTRL, m);
    wr(OFS_MASK_CFG, f);
    wr(OFS_MASK_EN, me);
    wr(OFS_MASK_LVL, ml);
    wr(OFS_AUX_CTRL, ax);
    dec[3:2] <= da[1:0];
    repeat (100) @(posedge clk);
    meas;
    chk_cnt(c_ah, eah);
    chk_cnt(c_al, eal);
    chk_cnt(c_r, er);
    chk_cnt(c_ev, eev);
  endtask
  task automatic t_reset;
    logic [5:0] ad [9];
    logic [7:0] ex [9];
    ad = '{OFS_MAIN_CTRL, OFS_SYNC_CTRL, OFS_MASK_CFG, OFS_MASK_EN, OFS_MASK_LVL,
      OFS_AUX_CTRL, OFS_DUTY0_LO, OFS_PERIOD_HI, OFS_DRV_STATUS};
    ex = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h09};
    for (int i = 0; i < 9; i++) begin
      rd(ad[i]);
      chk_val(rd_data, {24'h0, ex[i]});
      chk_val(rd_resp, AXI_OKAY);
    end
    rd(6'h3C);
    chk_val(rd_resp, AXI_SLVERR);
    wr(6'h3C, 8'hFF);
    chk_val(wr_resp, AXI_SLVERR);
    wr(OFS_COUNT_LO, 8'h55);
    repeat (20) @(posedge clk);
    rd(OFS_COUNT_LO);
    chk_val(rd_data, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_brake;
    wr(OFS_AUX_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    chk_val({ah, al, bh, bl}, 4'b0101);
    rd(OFS_DRV_STATUS);
    chk_val(rd_data, 32'h11);
    hall <= 1'b0;
    rd(OFS_DRV_STATUS);
    chk_val(rd_data, 32'h10);
    hall <= 1'b1;
    wr(OFS_AUX_CTRL, 8'h00);
    protect <= 1'b1;
    repeat (3) @(posedge clk);
    chk_val({ah, al, bh, bl}, 4'b0000);
    wr(OFS_MASK_CFG, 8'h06);
    repeat (3) @(posedge clk);
    chk_val({ah, al, bh, bl}, 4'b0101);
    protect <= 1'b0;
    $display("brake and protection test done");
  endtask
  task automatic t_hw;
    wr(OFS_PERIOD_HI, 8'h00);
    wr(OFS_PERIOD_LO, 8'h09);
    wr(OFS_DUTY0_HI, 8'h00);
    wr(OFS_DUTY0_LO, 8'h03);
    run_row(8'h01, 8'h04, 8'h1, 8'h0, 8'h0, 8'h0, 360, 0, 0, 0);
    run_row(8'h09, 8'h04, 8'h1, 8'h0, 8'h0, 8'h0, 252, 108, 36, 0);
    run_row(8'h09, 8'h0C, 8'h1, 8'h0, 8'h0, 8'h0, 0, 108, 36, 0);
    run_row(8'h09, 8'h05, 8'h2, 8'h0, 8'h0, 8'h0, 108, 252, 36, 0);
    run_row(8'h09, 8'h0D, 8'h2, 8'h0, 8'h0, 8'h0, 108, 0, 0, 0);
    run_row(8'h09, 8'h04, 8'h3, 8'h0, 8'h0, 8'h0, 0, 0, 0, 0);
    run_row(8'h09, 8'h00, 8'h1, 8'h0, 8'h0, 8'h0, 0, 360, 0, 0);
    run_row(8'h19, 8'h04, 8'h1, 8'h0, 8'h0, 8'h0, 252, 108, 18, 0);
    run_row(8'h29, 8'h04, 8'h1, 8'h0, 8'h0, 8'h0, 252, 108, 9, 0);
    run_row(8'h49, 8'h04, 8'h1, 8'h0, 8'h0, 8'h0, 252, 108, 36, 0);
    run_row(8'h89, 8'h04, 8'h1, 8'h0, 8'h0, 8'h0, 260, 100, 20, 0);
    run_row(8'h8B, 8'h04, 8'h1, 8'h0, 8'h0, 8'h0, 260, 100, 20, 20);
    run_row(8'h8D, 8'h04, 8'h1, 8'h0, 8'h0, 8'h0, 260, 100, 20, 20);
    run_row(8'hCF, 8'h04, 8'h1, 8'h0, 8'h0, 8'h0, 260, 100, 20, 40);
    chk_cnt(shorts, 0);
    $display("hardware mask test done");
  endtask
  task automatic t_sw;
    run_row(8'h09, 8'h84, 8'h1, 8'h0, 8'h0, 8'h0, 108, 108, 36, 0);
    run_row(8'h09, 8'h84, 8'h1, 8'h3, 8'h2, 8'h0, 0, 360, 0, 0);
    run_row(8'h09, 8'h84, 8'h1, 8'h3, 8'h3, 8'h0, 0, 0, 0, 0);
    run_row(8'h09, 8'h84, 8'h1, 8'h3, 8'h2, 8'h10, 108, 0, 0, 0);
    $display("software mask test done");
  endtask
  task automatic t_sync;
    run_row(8'h09, 8'h04, 8'h1, 8'h0, 8'h0, 8'h0, 252, 108, 36, 0);
    dec[1:0] <= 2'b01;
    wr(OFS_SYNC_CTRL, 8'h01);
    wr(OFS_DUTY0_HI, 8'h00);
    wr(OFS_DUTY0_LO, 8'h05);
    repeat (100) @(posedge clk);
    meas;
    chk_cnt(c_al, 180);
    chk_cnt(c_bl, 180);
    wr(OFS_SYNC_CTRL, 8'h02);
    wr(OFS_DUTY0_LO, 8'h02);
    wr(OFS_DUTY1_HI, 8'h00);
    wr(OFS_DUTY1_LO, 8'h07);
    repeat (100) @(posedge clk);
    meas;
    chk_cnt(c_al, 180);
    chk_cnt(c_bl, 180);
    wr(OFS_SYNC_CTRL, 8'h06);
    repeat (100) @(posedge clk);
    rd(OFS_SYNC_CTRL);
    chk_val(rd_data, 32'h02);
    meas;
    chk_cnt(c_al, 72);
    chk_cnt(c_bl, 252);
    rd(OFS_COUNT_LO);
    chk_val({31'h0, rd_data <= 32'd9}, 32'h1);
    $display("sync update test done");
  endtask
  // slow counter, aligned to a fresh period so no wrap falls inside the early checks
  task automatic t_phase;
    wr(OFS_MAIN_CTRL, 8'h39);
    do rd(OFS_COUNT_LO); while (rd_data !== 32'h1);
    wr(OFS_SYNC_CTRL, 8'h08);
    dec[3:2] <= 2'b10;
    repeat (3) @(posedge clk);
    chk_val({ah, al}, 2'b10);
    wr(OFS_SYNC_CTRL, 8'h00);
    dec[3:2] <= 2'b11;
    repeat (3) @(posedge clk);
    chk_val({ah, al}, 2'b10);
    repeat (80) @(posedge clk);
    chk_val({ah, al}, 2'b00);
    $display("phase update test done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_brake;
    t_hw;
    t_sw;
    t_sync;
    t_phase;
    summarize;
  end
  // about 11000 cycles are expected; the limit leaves ample margin
  initial begin
    #200000;
    failures++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    summarize;
  end
endmodule
`default_nettype wire
